/* File: pkg/bms_params.svh */
`ifndef BMS_PARAMS_SVH
`define BMS_PARAMS_SVH
// Bus pin levels
`define BMS_ON_N 1'b0
`define BMS_OFF_N 1'b1
`define BMS_DIR_READ 1'b1
`define BMS_DIR_WRITE 1'b0
// Bus width strap level that selects the sixteen-bit bus
`define BMS_MODE_WIDE 1'b1
// Byte lane fields
`define BMS_LANE_HI 15:8
`define BMS_LANE_LO 7:0
`define BMS_A0 0
`define BMS_ZERO_BYTE 8'h00
`endif

/* File: pkg/bms_pkg.sv */
package bms_pkg;
  localparam int BMS_AW = 24;
  localparam int BMS_DW = 16;

  typedef struct packed {
    logic rmw;
    logic wordOp;
    logic [2:0] fc;
    logic [BMS_AW-1:0] addr;
  } bms_req_t;

  typedef struct packed {
    logic [BMS_DW-1:0] data;
    logic fault;
    logic slow;
  } bms_rsp_t;

  typedef struct packed {
    logic upper;
    logic lower;
    logic single8;
  } bms_lane_t;

  typedef struct packed {
    logic ack;
    logic fault;
    logic slow;
    logic any;
  } bms_term_t;

  typedef enum logic [4:0] {
    ST_IDLE, ST_S0, ST_S1, ST_S2, ST_S3, ST_S4, ST_S5, ST_S6, ST_S7,
    ST_S8, ST_S9, ST_S10, ST_S11, ST_S12, ST_S13, ST_S14, ST_S15,
    ST_S16, ST_S17, ST_S18, ST_S19, ST_WAIT, ST_FS8, ST_FS9
  } bms_state_t;
endpackage

/* File: hw/bms_lane_sel.sv */
`timescale 1ns/1ps
`include "bms_params.svh"
module bms_lane_sel
  import bms_pkg::*;
(
  input wire logic wide16,
  input wire logic wordOp,
  input wire logic addrLsb,
  output bms_lane_t lane
);
  wire logic byteUpper;
  wire logic byteLower;
  // Byte lane from internal A0: zero picks upper, one picks lower
  assign byteUpper = !wordOp && (addrLsb == 1'b0);
  assign byteLower = !wordOp && (addrLsb == 1'b1);
  // Words use both lanes at once; narrow bus keeps upper negated
  assign lane.upper = wide16 && (wordOp || byteUpper);
  assign lane.lower = wide16 && (wordOp || byteLower);
  assign lane.single8 = !wide16;
endmodule

/* File: hw/bms_term_detect.sv */
`timescale 1ns/1ps
`include "bms_params.svh"
module bms_term_detect
  import bms_pkg::*;
(
  input wire logic transferAckN,
  input wire logic busFaultInN,
  input wire logic slowPeriphReqN,
  output bms_term_t term
);
  wire logic ackSeen;
  wire logic faultSeen;
  wire logic slowSeen;
  assign ackSeen = (transferAckN == `BMS_ON_N);
  assign faultSeen = (busFaultInN == `BMS_ON_N);
  assign slowSeen = (slowPeriphReqN == `BMS_ON_N);
  // Acknowledge wins; fault counts only in its absence; slow request last
  assign term.ack = ackSeen;
  assign term.fault = faultSeen && !ackSeen;
  assign term.slow = slowSeen && !ackSeen && !faultSeen;
  assign term.any = ackSeen || faultSeen || slowSeen;
endmodule

/* File: hw/bms_cycle_seq.sv */
`timescale 1ns/1ps
`include "bms_params.svh"
// Behaviour
// - Address strobe held across whole read-modify-write
// - Read-modify-write is byte only, same address
// - S0 codes and read direction, S1 address
// - S2 strobes asserted, S3 nothing changes
// - Wait whole clocks until acknowledge or fault
// - Slow request at S4/S16 diverts the cycle
// - Capture data entering S7, drop data strobe
// - S8 to S11 bus held while byte modified
// - Write portion S12 keeps codes, address, strobe
// - S14 direction low, S15 drive data
// - S16 write strobe, wait, S17-S18 quiet
// - S19 negate strobes, then float and read
// - Mode high at reset selects wide bus
// - Wide bus addresses from A1, sixteen data bits
// - Wide-bus word reads assert both lane strobes together
// - Byte lane chosen by internal A0
// - Basic read spans S0 to S7
// - S7 capture, negate strobes, float address
// - Sample termination from S4, data at S6
// - Fault without acknowledge ends at S9
// - Mode low at reset: narrow bus, upper off
module bms_cycle_seq
  import bms_pkg::*;
#(
  parameter int AW = BMS_AW,
  parameter int DW = BMS_DW
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic modeIn,
  input wire logic reqValid,
  output logic reqReady,
  input bms_req_t reqIn,
  output logic rspValid,
  output bms_rsp_t rsp,
  output logic [7:0] aluReadByte,
  output logic aluActive,
  input wire logic [7:0] aluByte,
  output logic busLock,
  output logic wide16,
  output logic [2:0] cycleSpaceCode,
  output logic cycleSpaceOe,
  output logic [AW-1:0] addrOut,
  output logic addrOe,
  output logic [DW-1:0] dataOut,
  output logic dataOe,
  input wire logic [DW-1:0] dataIn,
  output logic addressStrobeN,
  output logic upperByteStrobeN,
  output logic lowerByteStrobeN,
  output logic byteDataStrobeN,
  output logic transferDirection,
  input wire logic transferAckN,
  input wire logic busFaultInN,
  input wire logic slowPeriphReqN
);
  bms_state_t state_q, state_d;
  bms_req_t req_q;
  logic wide16_q;
  logic writePart_q;
  logic fault_q, fault_d;
  logic [DW-1:0] rdData_q;
  logic [7:0] modByte_q;
  logic rspValid_q, slow_q;
  logic as_q, uds_q, lds_q, ds_q, rw_q, addrOe_q, dataOe_q, fcOe_q;

  wire logic start;
  wire bms_req_t reqD;
  wire bms_lane_t lane;
  wire bms_term_t term;
  wire logic inTermState;
  wire logic writePartD;
  wire logic rmwD;
  wire logic rdStrobe, wrStrobe, strobeOn;
  wire logic asOn, rwWrite, addrOn, dataOn;
  wire logic ending;
  wire logic [DW-1:0] capData;

  assign start = reqValid && (state_q == ST_IDLE);
  assign reqReady = (state_q == ST_IDLE);
  // Read-modify-write forces a single byte
  assign reqD = start ? bms_req_t'{rmw: reqIn.rmw, wordOp: reqIn.wordOp && !reqIn.rmw,
                          fc: reqIn.fc, addr: reqIn.addr} : req_q;
  assign rmwD = reqD.rmw;

  bms_lane_sel u_lane (
    .wide16(wide16_q),
    .wordOp(reqD.wordOp),
    .addrLsb(reqD.addr[`BMS_A0]),
    .lane(lane)
  );

  bms_term_detect u_term (
    .transferAckN(transferAckN),
    .busFaultInN(busFaultInN),
    .slowPeriphReqN(slowPeriphReqN),
    .term(term)
  );

  // Bus width strap caught while reset is held
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wide16_q <= (modeIn == `BMS_MODE_WIDE);
    end
  end

  assign inTermState = (state_q == ST_S4) || (state_q == ST_S16);

  // Sequencer: one clk per bus state; a wait is two clks (one whole bus clock)
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (start) state_d = ST_S0;
      ST_S0: state_d = ST_S1;
      ST_S1: state_d = ST_S2;
      ST_S2: state_d = ST_S3;
      ST_S3: state_d = ST_S4;
      ST_S4, ST_S16: begin
        if (term.slow) begin
          state_d = ST_IDLE;
        end else if (term.ack || term.fault) begin
          state_d = (state_q == ST_S4) ? ST_S5 : ST_S17;
        end else begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: state_d = writePart_q ? ST_S16 : ST_S4;
      ST_S5: state_d = ST_S6;
      ST_S6: state_d = ST_S7;
      ST_S7: begin
        if (fault_q) begin
          state_d = ST_FS8;
        end else if (req_q.rmw) begin
          state_d = ST_S8;
        end else begin
          state_d = ST_IDLE;
        end
      end
      ST_S8: state_d = ST_S9;
      ST_S9: state_d = ST_S10;
      ST_S10: state_d = ST_S11;
      ST_S11: state_d = ST_S12;
      ST_S12: state_d = ST_S13;
      ST_S13: state_d = ST_S14;
      ST_S14: state_d = ST_S15;
      ST_S15: state_d = ST_S16;
      ST_S17: state_d = fault_q ? ST_FS8 : ST_S18;
      ST_S18: state_d = ST_S19;
      ST_S19: state_d = ST_IDLE;
      ST_FS8: state_d = ST_FS9;
      ST_FS9: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  assign fault_d = (state_q == ST_IDLE) ? 1'b0 : (fault_q || (inTermState && term.fault));
  assign writePartD = (state_d inside {[ST_S12:ST_S19]}) ||
                      ((state_d == ST_WAIT) && writePart_q);

  // Bus pin decode from the next state so the pins change with the state
  assign rdStrobe = (state_d inside {[ST_S2:ST_S6]}) ||
                    ((state_d == ST_WAIT) && !writePartD);
  assign wrStrobe = !fault_d && ((state_d inside {[ST_S16:ST_S18]}) ||
                    ((state_d == ST_WAIT) && writePartD));
  assign strobeOn = rdStrobe || wrStrobe;
  // Strobe stays low through the modify and write; a read fault ends it at S7, a write fault at S17
  assign asOn = (state_d inside {[ST_S2:ST_S6]}) || (state_d == ST_WAIT) ||
                (rmwD && !fault_d && (state_d inside {[ST_S7:ST_S18]}));
  assign rwWrite = rmwD && !fault_d && ((state_d inside {[ST_S14:ST_S19]}) ||
                   ((state_d == ST_WAIT) && writePartD));
  assign addrOn = (state_d inside {[ST_S1:ST_S6]}) || (state_d == ST_WAIT) ||
                  (rmwD && !fault_d && (state_d inside {[ST_S7:ST_S19]}));
  assign dataOn = rmwD && !fault_d && ((state_d inside {[ST_S15:ST_S19]}) ||
                  ((state_d == ST_WAIT) && writePartD));

  always_ff @(posedge clk) begin
    if (!rstn) begin
      as_q <= 1'b0;
      uds_q <= 1'b0;
      lds_q <= 1'b0;
      ds_q <= 1'b0;
      rw_q <= 1'b0;
      addrOe_q <= 1'b0;
      dataOe_q <= 1'b0;
      fcOe_q <= 1'b0;
    end else begin
      as_q <= asOn;
      uds_q <= strobeOn && lane.upper;
      lds_q <= strobeOn && lane.lower;
      ds_q <= strobeOn && lane.single8;
      rw_q <= rwWrite;
      addrOe_q <= addrOn;
      dataOe_q <= dataOn;
      fcOe_q <= (state_d != ST_IDLE);
    end
  end

  // Read data positioned by lane; narrow-bus bytes use the low byte, words take all of dataIn
  assign capData = reqD.wordOp ? dataIn :
                   (lane.upper ? {`BMS_ZERO_BYTE, dataIn[`BMS_LANE_HI]} :
                                 {`BMS_ZERO_BYTE, dataIn[`BMS_LANE_LO]});
  assign ending = (state_d == ST_IDLE) && (state_q != ST_IDLE);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      req_q <= '0;
      writePart_q <= 1'b0;
      fault_q <= 1'b0;
      rdData_q <= '0;
      modByte_q <= '0;
      rspValid_q <= 1'b0;
      slow_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (start) begin
        req_q <= reqD;
      end
      writePart_q <= writePartD;
      fault_q <= fault_d;
      if (state_q == ST_S6) begin
        rdData_q <= capData;
      end
      if (state_q == ST_S11) begin
        modByte_q <= aluByte;
      end
      rspValid_q <= ending;
      slow_q <= ending && inTermState && term.slow;
    end
  end

  assign rspValid = rspValid_q;
  assign rsp = '{data: rdData_q, fault: fault_q, slow: slow_q};
  assign aluReadByte = rdData_q[`BMS_LANE_LO];
  assign aluActive = (state_q inside {[ST_S8:ST_S11]});
  // Bus held for this master until the sequencer returns to idle
  assign busLock = (state_q != ST_IDLE);
  assign wide16 = wide16_q;
  assign cycleSpaceCode = req_q.fc;
  assign cycleSpaceOe = fcOe_q;
  // Wide bus: bit zero is not a pin and reads zero
  assign addrOut = wide16_q ? {req_q.addr[AW-1:1], 1'b0} : req_q.addr;
  assign addrOe = addrOe_q;
  assign dataOut = {modByte_q, modByte_q};
  assign dataOe = dataOe_q;
  assign addressStrobeN = !as_q;
  assign upperByteStrobeN = !uds_q;
  assign lowerByteStrobeN = !lds_q;
  assign byteDataStrobeN = !ds_q;
  assign transferDirection = !rw_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_rmw_strobe_hold: assert property (
    (state_q == ST_S7 && req_q.rmw && !fault_q) |-> !addressStrobeN [*8]
  ) else $error("address strobe dropped inside read-modify-write");
  a_rmw_one_lane: assert property (
    req_q.rmw && state_q != ST_IDLE |-> (upperByteStrobeN || lowerByteStrobeN)
  ) else $error("read-modify-write used both lanes");
  a_s0_read_code: assert property (
    state_q == ST_S0 |-> transferDirection && cycleSpaceOe ##1 addrOe
  ) else $error("S0/S1 direction, code or address wrong");
  a_s2_strobes_on: assert property (
    state_q == ST_S2 |-> !addressStrobeN &&
      (!upperByteStrobeN || !lowerByteStrobeN || !byteDataStrobeN) ##1 $stable(addressStrobeN)
  ) else $error("S2 strobes not asserted or S3 changed");
  a_wait_insert: assert property (
    inTermState && !term.any |=> state_q == ST_WAIT ##1 (state_q inside {ST_S4, ST_S16})
  ) else $error("wait state not inserted as a whole clock");
  a_slow_divert: assert property (
    inTermState && term.slow |=> state_q == ST_IDLE && rspValid && rsp.slow
  ) else $error("slow request did not divert the cycle");
  a_read_capture: assert property (
    state_q == ST_S6 && !req_q.wordOp && !wide16_q |=>
      rsp.data[`BMS_LANE_LO] == $past(dataIn[`BMS_LANE_LO]) && upperByteStrobeN
  ) else $error("read byte not captured entering S7");
  a_alu_bus_hold: assert property (
    state_q inside {[ST_S9:ST_S11]} |-> $stable(addressStrobeN) &&
      $stable(transferDirection) && $stable(addrOe) && $stable(dataOe)
  ) else $error("bus moved while byte modified");
  a_write_dir_data: assert property (
    state_q == ST_S13 && !fault_q |=> !transferDirection && !dataOe ##1 dataOe
  ) else $error("direction or data drive wrong at S14/S15");
  a_s19_release: assert property (
    state_q == ST_S19 |-> addressStrobeN && upperByteStrobeN && lowerByteStrobeN
      && byteDataStrobeN ##1 !addrOe && !dataOe && transferDirection
  ) else $error("S19 release wrong");
  a_fault_stretch: assert property (
    state_q == ST_S7 && fault_q |=> state_q == ST_FS8 ##1 state_q == ST_FS9 ##1 rspValid
  ) else $error("fault cycle not ended at S9");
  a_narrow_upper: assert property (
    !wide16_q |-> upperByteStrobeN
  ) else $error("upper strobe asserted on narrow bus");
  a_write_keep_bus: assert property (
    state_q inside {ST_S12, ST_S13} |-> $stable(addressStrobeN) &&
      $stable(transferDirection) && $stable(addrOut) && $stable(addrOe) &&
      $stable(cycleSpaceCode) && $stable(cycleSpaceOe)
  ) else $error("bus moved at start of write portion");
  a_write_strobe_on: assert property (
    state_q == ST_S15 && !fault_q |=> !addressStrobeN &&
      (!upperByteStrobeN || !lowerByteStrobeN || !byteDataStrobeN)
  ) else $error("write strobe not asserted at S16");
  a_write_quiet: assert property (
    state_q inside {ST_S17, ST_S18} && !fault_q |-> $stable(addressStrobeN) &&
      $stable(upperByteStrobeN) && $stable(lowerByteStrobeN) && $stable(byteDataStrobeN) &&
      $stable(transferDirection) && $stable(dataOe)
  ) else $error("bus moved during S17 or S18");
  a_idle_released: assert property (
    state_q == ST_IDLE |-> addressStrobeN && transferDirection && !addrOe && !dataOe
  ) else $error("bus not released while idle");
  a_wide_addr_a1: assert property (
    wide16_q |-> addrOut[`BMS_A0] == 1'b0
  ) else $error("wide bus drove address bit zero");
  a_word_lanes: assert property (
    state_q == ST_S2 && req_q.wordOp && wide16_q |-> !upperByteStrobeN && !lowerByteStrobeN
  ) else $error("word read did not use both lanes");
  a_byte_lane_pick: assert property (
    state_q == ST_S2 && !req_q.wordOp && wide16_q |->
      upperByteStrobeN == req_q.addr[`BMS_A0] && lowerByteStrobeN == !req_q.addr[`BMS_A0]
  ) else $error("byte lane does not follow address bit zero");
  a_read_eight: assert property (
    state_q == ST_S5 && !req_q.rmw && !fault_q |=> state_q == ST_S6 ##1 state_q == ST_S7
      ##1 state_q == ST_IDLE && rspValid
  ) else $error("basic read did not end after S7");
  a_s7_release: assert property (
    state_q == ST_S7 && !req_q.rmw |-> addressStrobeN && upperByteStrobeN &&
      lowerByteStrobeN && byteDataStrobeN && !addrOe
  ) else $error("S7 strobes or address not released");
  a_fault_sample: assert property (
    inTermState && term.fault |=> fault_q
  ) else $error("fault not sampled in S4 or S16");
  a_alu_window: assert property (
    state_q == ST_S7 && req_q.rmw && !fault_q |=> aluActive [*4] ##1 !aluActive
  ) else $error("modify window not four states");
  a_lock_release: assert property (
    state_q == ST_S19 |-> busLock ##1 !busLock
  ) else $error("bus lock not held to S19");

  c_word_read: cover property (state_q == ST_S7 && req_q.wordOp);
  c_rmw_done: cover property (state_q == ST_S19);
  c_wait_write: cover property (state_q == ST_WAIT && writePart_q);
  c_fault_end: cover property (state_q == ST_FS9);
  c_slow_divert: cover property (inTermState && term.slow);
endmodule

/* File: sim/bms_slave_model.sv */
`timescale 1ns/1ps
module bms_slave_model (
  input wire logic clk,
  input wire logic [1:0] mode,
  input wire logic [3:0] waits,
  input wire logic [15:0] readWord,
  input wire logic asN,
  input wire logic upN,
  input wire logic loN,
  input wire logic dsN,
  input wire logic dir,
  input wire logic dataOe,
  input wire logic [15:0] dataOut,
  output logic [15:0] dataIn,
  output logic ackN,
  output logic faultN,
  output logic slowN,
  output logic [7:0] wrByte
);
  logic [4:0] cnt = 5'h0;
  logic active;
  wire sLow = !upN || !loN || !dsN;
  // Read portion answers late by whole clocks, write portion answers at once
  assign active = sLow && (!dir || cnt >= 5'(2 + 2 * waits));
  // Answer dropped as soon as the strobes are negated
  assign ackN = !(active && mode == 2'h0);
  assign faultN = !(active && mode == 2'h1);
  assign slowN = !(active && mode == 2'h2);
  // Released bus shows the inverse of the driven word
  assign dataIn = (!asN && dir) ? readWord : ~readWord;
  always @(negedge clk) begin
    cnt <= sLow ? cnt + 5'h1 : 5'h0;
    if (sLow && !dir && dataOe) begin
      wrByte <= upN ? dataOut[7:0] : dataOut[15:8];
    end
  end
endmodule

/* File: sim/async_bus_cycle_sequencer_tb.sv */
`timescale 1ns/1ps
module async_bus_cycle_sequencer_tb
  import bms_pkg::*;
;
  logic clk = 1'b0, rstn = 1'b0, modeIn = 1'b1, reqValid = 1'b0;
  logic reqReady, rspValid, aluActive, busLock, wide16, cycleSpaceOe, addrOe, dataOe;
  logic asN, upN, loN, dsN, dir, ackN, faultN, slowN;
  bms_req_t reqIn = '0;
  bms_rsp_t rsp;
  logic [7:0] aluReadByte, wrByte, aluByte = 8'h5a;
  logic [2:0] fc;
  logic [23:0] addrOut;
  logic [15:0] dataOut, dataIn;
  logic [1:0] mode = 2'h0;
  logic [3:0] waits = 4'h0;
  int miscompares = 0, nCompared = 0, cycles = 0;
  int nClk, asLow, upLow, loLow, dsLow, dirLow, asRise, aluHi, lockHi, fcOn;
  logic [23:0] seenAddr;
  logic [2:0] seenFc;

  always #50 clk = ~clk;

  bms_cycle_seq u_dut (.clk(clk), .rstn(rstn), .modeIn(modeIn), .reqValid(reqValid),
    .reqReady(reqReady), .reqIn(reqIn), .rspValid(rspValid), .rsp(rsp),
    .aluReadByte(aluReadByte), .aluActive(aluActive), .aluByte(aluByte), .busLock(busLock),
    .wide16(wide16), .cycleSpaceCode(fc), .cycleSpaceOe(cycleSpaceOe), .addrOut(addrOut),
    .addrOe(addrOe), .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn),
    .addressStrobeN(asN), .upperByteStrobeN(upN), .lowerByteStrobeN(loN),
    .byteDataStrobeN(dsN), .transferDirection(dir), .transferAckN(ackN),
    .busFaultInN(faultN), .slowPeriphReqN(slowN));

  bms_slave_model u_slave (.clk(clk), .mode(mode), .waits(waits), .readWord(16'ha5c3),
    .asN(asN), .upN(upN), .loN(loN), .dsN(dsN), .dir(dir), .dataOe(dataOe),
    .dataOut(dataOut), .dataIn(dataIn), .ackN(ackN), .faultN(faultN), .slowN(slowN),
    .wrByte(wrByte));

  task automatic complete_run();
    $display("compared %0d mismatches %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nCompared++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic do_reset(input logic strap);
    @(negedge clk);
    rstn = 1'b0;
    modeIn = strap;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
  endtask

  // One cycle from request to rspValid, counting strobe clocks at the falling edge
  task automatic run(input logic rmw, input logic wordOp, input logic [23:0] addr);
    logic prevAs;
    reqIn = '{rmw: rmw, wordOp: wordOp, fc: 3'h5, addr: addr};
    reqValid = 1'b1;
    @(posedge clk);
    {nClk, asLow, upLow, loLow, dsLow, dirLow, asRise, aluHi, lockHi, fcOn} = '0;
    prevAs = 1'b1;
    do begin
      @(negedge clk);
      if (nClk == 0) begin
        reqValid = 1'b0;
      end
      nClk++;
      asLow += int'(asN === 1'b0);
      upLow += int'(upN === 1'b0);
      loLow += int'(loN === 1'b0);
      dsLow += int'(dsN === 1'b0);
      dirLow += int'(dir === 1'b0);
      asRise += int'(prevAs === 1'b0 && asN === 1'b1);
      aluHi += int'(aluActive === 1'b1);
      lockHi += int'(busLock === 1'b1);
      fcOn += int'(cycleSpaceOe === 1'b1);
      prevAs = asN;
      if (asN === 1'b0) begin
        seenAddr = addrOut;
        seenFc = fc;
      end
    end while (rspValid !== 1'b1 && nClk < 100);
  endtask

  task automatic t_reset();
    chk("idle pins", 8'hf9, {asN, upN, loN, dsN, dir, dataOe, addrOe, reqReady});
    chk("width", 1, wide16);
  endtask

  task automatic t_word();
    run(1'b0, 1'b1, 24'h000102);
    chk("word latency", 9, nClk);
    chk("word data", 16'ha5c3, rsp.data);
    chk("word lanes", {8'd5, 8'd5, 8'd5}, {8'(asLow), 8'(upLow), 8'(loLow)});
    chk("word code", 3'h5, seenFc);
    chk("word lock", {8'd8, 8'd8}, {8'(lockHi), 8'(fcOn)});
  endtask

  task automatic t_bytes();
    for (int a = 0; a < 2; a++) begin
      run(1'b0, 1'b0, 24'h000200 | 24'(a));
      chk("byte data", a ? 16'h00c3 : 16'h00a5, rsp.data);
      chk("byte lanes", a ? {8'd0, 8'd5} : {8'd5, 8'd0}, {8'(upLow), 8'(loLow)});
      chk("byte addr", 24'h000200, seenAddr);
    end
  endtask

  task automatic t_wait();
    waits = 4'h2;
    run(1'b0, 1'b1, 24'h000104);
    waits = 4'h0;
    chk("wait latency", 13, nClk);
    chk("wait strobe", 9, asLow);
  endtask

  task automatic t_fault();
    mode = 2'h1;
    run(1'b0, 1'b1, 24'h000106);
    chk("fault latency", 11, nClk);
    chk("fault flag", 2'b10, {rsp.fault, rsp.slow});
    chk("fault strobe", 5, asLow);
  endtask

  task automatic t_slow();
    mode = 2'h2;
    run(1'b0, 1'b1, 24'h000108);
    mode = 2'h0;
    chk("slow latency", 6, nClk);
    chk("slow flag", 2'b01, {rsp.fault, rsp.slow});
    chk("slow lock", 5, lockHi);
  endtask

  task automatic t_rmw();
    run(1'b1, 1'b1, 24'h000013);
    chk("rmw latency", 21, nClk);
    chk("rmw strobe", {8'd17, 8'd1}, {8'(asLow), 8'(asRise)});
    chk("rmw lanes", {8'd0, 8'd8}, {8'(upLow), 8'(loLow)});
    chk("rmw dir", 6, dirLow);
    chk("rmw read", 8'hc3, aluReadByte);
    chk("rmw modify", {8'd4, 8'd20}, {8'(aluHi), 8'(lockHi)});
    chk("rmw write", 8'h5a, wrByte);
    chk("rmw addr", 24'h000012, seenAddr);
    chk("rmw end", 3'b100, {dir, dataOe, addrOe});
  endtask

  task automatic t_narrow();
    do_reset(1'b0);
    chk("narrow width", 0, wide16);
    run(1'b0, 1'b0, 24'h000301);
    chk("narrow data", 16'h00c3, rsp.data);
    chk("narrow lanes", {8'd0, 8'd5}, {8'(upLow), 8'(dsLow)});
  endtask

  initial begin
    do_reset(1'b1);
    t_reset();
    t_word();
    t_bytes();
    t_wait();
    t_fault();
    t_slow();
    t_rmw();
    t_narrow();
    complete_run();
  end
endmodule
